// file: ctbc_pkg.sv
// Package with register map, field positions, reset values and timing counts of the clock and time base block.
// Function
// - Two-bit system clock select: main/2, main/4, main/64, alternate/2; code uses time base/2 there, main/256 when time base source is main.
// - A system reset selects main oscillator divided by 64.
// - Clearing main enable stops oscillator, presets prescaler and power-on counter to 0x78.
// - Setting main enable restarts oscillator; ready flag set after 8072 counts.
// - Main ready flag read-only, cleared by power-on or disable.
// - Alternate ready flag read-only, set after 8072 time base counts, then sticky.
// - Alternate oscillator always runs and may feed system clock and time base.
// - Power-on loads the 14-bit time base prescaler with 0x78.
// - Time base source bit: 1 main/128, 0 alternate; resets to 0.
// - Time base source bit accepts only one write after each reset.
// - Time base provides LCD, real-time interrupt and watchdog clocks.
// - LCD clock: main/8192 or /16384, alternate/64 or /128.
// - Timer 2 rate field divides system clock by 1, 4, 32 or 256.
// - Timer 2 prescaled clock is offered to gate the timer 2 event input.
// - Option map bit selects option memory map when 1.
package ctbc_pkg;
  localparam logic [7:0]  ADDR_TBC         = 8'h10;
  localparam logic [7:0]  ADDR_MISC        = 8'h11;
  localparam logic [7:0]  ADDR_IRQ_STATUS  = 8'h12;
  localparam logic [7:0]  ADDR_IRQ_MASK    = 8'h13;
  localparam int          TBC_SRC_BIT      = 7;
  localparam int          TBC_LCD_BIT      = 5;
  localparam int          TBC_RATE_HI      = 1;
  localparam int          TBC_RATE_LO      = 0;
  localparam logic [7:0]  TBC_WMASK        = 8'hA3;
  localparam int          MISC_SYS_HI      = 7;
  localparam int          MISC_SYS_LO      = 6;
  localparam int          MISC_MAIN_RDY    = 5;
  localparam int          MISC_ALT_RDY     = 4;
  localparam int          MISC_MAIN_EN     = 3;
  localparam int          MISC_OPT_MAP     = 2;
  localparam logic [1:0]  SYS_MAIN_DIV2    = 2'h0;
  localparam logic [1:0]  SYS_MAIN_DIV4    = 2'h1;
  localparam logic [1:0]  SYS_MAIN_DIV64   = 2'h2;
  localparam logic [1:0]  SYS_ALT_DIV2     = 2'h3;
  localparam logic [7:0]  TBC_RESET        = 8'h00;
  localparam logic [13:0] PRESET_VALUE     = 14'h0078;
  localparam logic [13:0] STARTUP_COUNTS   = 14'h1F88;
  localparam int          IRQ_MAIN_RDY     = 0;
  localparam int          IRQ_ALT_RDY      = 1;
  localparam int          MAIN_DIV128_BIT  = 6;
  localparam int          ALT_DIV_SEL_BIT  = 6;
  localparam int          TB_LCD_MAIN_LO   = 5;
  localparam int          TB_LCD_ALT_LO    = 5;
endpackage : ctbc_pkg

// file: ctbc_edge.sv
// Rising edge pulse generator for an internal divided clock level.
module ctbc_edge (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic resetn,
  // Level in, pulse out
  input  wire logic lvl,
  output logic      pulse
);
  logic lvl_ff;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      lvl_ff <= 1'b0;
    end else begin
      lvl_ff <= lvl;
    end
  end
  assign pulse = lvl & ~lvl_ff;
endmodule : ctbc_edge

// file: ctbc_div.sv
// Free running binary divider advanced by an enable pulse, with synchronous preset.
module ctbc_div #(
  parameter int W = 14
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         resetn,
  // Control
  input  wire logic         tick,
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Count
  output logic [W-1:0]      cnt
);
  logic [W-1:0] cnt_ff;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (load) begin
      cnt_ff <= load_val;
    end else if (tick) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
  assign cnt = cnt_ff;
endmodule : ctbc_div

// file: ctbc_top.sv
// Clock selection, oscillator start-up and time base control with an Avalon-MM register slave.
module ctbc_top (
  // Clock and resets
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       por_n,
  // Oscillator ticks, one ref_clk cycle per oscillator edge
  input  wire logic       main_osc_tick,
  input  wire logic       alt_osc_tick,
  // Avalon-MM slave
  input  wire logic [7:0] avs_address,
  input  wire logic       avs_read,
  input  wire logic       avs_write,
  input  wire logic [7:0] avs_writedata,
  output logic [7:0]      avs_readdata,
  output logic            avs_waitrequest,
  // Clock enables and status out
  output logic            main_osc_run,
  output logic            sysclk_tick,
  output logic            tb_tick,
  output logic            lcd_clk_tick,
  output logic            tmr2_prescaled_clk,
  output logic            option_map_sel,
  output logic            irq
);
  logic [7:0]  tbc_ff;
  logic        src_written_ff;
  logic [1:0]  sys_sel_ff;
  logic        main_en_ff;
  logic        main_rdy_ff;
  logic        alt_rdy_ff;
  logic        opt_ff;
  logic [1:0]  ista_ff;
  logic [1:0]  imask_ff;
  logic        ack_ff;
  logic        waitreq_ff;
  logic [7:0]  rdata_ff;
  logic        por_seen_ff;
  logic        sys_ff;
  logic        tb_ff;
  logic        lcd_ff;
  logic        t2_ff;
  logic        irq_ff;
  logic [6:0]  sys_pre;
  logic [13:0] tb_pre;
  logic [13:0] por_cnt;
  logic [7:0]  t2_pre;
  logic [13:0] main_cnt_ff;
  logic [13:0] alt_cnt_ff;
  logic        main_tick_g;
  logic        sys_lvl;
  logic        tb_src_tick;
  logic        tb_pulse;
  logic        lcd_lvl;
  logic        t2_lvl;
  logic        sys_pulse;
  logic        wr;
  logic        rd;
  logic        osc_preset;
  logic        main_rdy_set;
  logic        alt_rdy_set;
  logic [1:0]  nxt_ista;
  logic [7:0]  nxt_rdata;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction : hit

  // One wait state: each access is completed on the cycle after it is seen.
  assign wr = avs_write & ~ack_ff;
  assign rd = avs_read & ~ack_ff;
  assign osc_preset = wr & hit(avs_address, ctbc_pkg::ADDR_MISC) & ~avs_writedata[ctbc_pkg::MISC_MAIN_EN];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= (avs_read | avs_write) & ~ack_ff;
    end
  end

  // Waitrequest is kept as its own flop, the inverse of the next acknowledge, so the bus sees a register.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      waitreq_ff <= 1'b1;
    end else begin
      waitreq_ff <= ~((avs_read | avs_write) & ~ack_ff);
    end
  end
  assign avs_waitrequest = waitreq_ff;

  // Main oscillator is gated by its enable.
  assign main_tick_g = main_osc_tick & main_en_ff;

  ctbc_div #(.W(7)) u_sys_pre (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .tick     (main_tick_g),
    .load     (osc_preset),
    .load_val (ctbc_pkg::PRESET_VALUE[6:0]),
    .cnt      (sys_pre)
  );

  // Power-on counter counts main ticks up from its preset until main ready; readiness itself is timed by main_cnt_ff from the enable.
  ctbc_div #(.W(14)) u_por_cnt (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .tick     (main_tick_g & ~main_rdy_ff),
    .load     (osc_preset | ~por_seen_ff),
    .load_val (ctbc_pkg::PRESET_VALUE),
    .cnt      (por_cnt)
  );

  // Time base source: main/128 edge or the alternate oscillator tick.
  assign tb_src_tick = tbc_ff[ctbc_pkg::TBC_SRC_BIT] ?
                       (main_tick_g & (sys_pre == 7'h7F)) : alt_osc_tick;

  ctbc_div #(.W(14)) u_tb_pre (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .tick     (tb_src_tick),
    .load     (~por_seen_ff),
    .load_val (ctbc_pkg::PRESET_VALUE),
    .cnt      (tb_pre)
  );

  // Timer 2 prescaler runs from system clock edges.
  ctbc_div #(.W(8)) u_t2_pre (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .tick     (sys_pulse),
    .load     (1'b0),
    .load_val (8'h00),
    .cnt      (t2_pre)
  );

  // Power-on latch: lets the time base prescaler and power-on counter take their preset once after power is applied.
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      por_seen_ff <= 1'b0;
    end else begin
      por_seen_ff <= 1'b1;
    end
  end

  // Start-up counts measured from enable or power-on, not from the preset value.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      main_cnt_ff <= 14'h0000;
    end else if (osc_preset || !main_en_ff) begin
      main_cnt_ff <= 14'h0000;
    end else if (main_tick_g && main_cnt_ff != ctbc_pkg::STARTUP_COUNTS) begin
      main_cnt_ff <= main_cnt_ff + 14'h0001;
    end
  end

  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      alt_cnt_ff <= 14'h0000;
    end else if (tb_src_tick && alt_cnt_ff != ctbc_pkg::STARTUP_COUNTS) begin
      alt_cnt_ff <= alt_cnt_ff + 14'h0001;
    end
  end

  assign main_rdy_set = main_en_ff & (main_cnt_ff == ctbc_pkg::STARTUP_COUNTS);
  assign alt_rdy_set = (alt_cnt_ff == ctbc_pkg::STARTUP_COUNTS);

  // Main ready is cleared only by power-on or by disabling the oscillator.
  // Disabling wins over a count match in the same cycle, since the count is stale then.
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      main_rdy_ff <= 1'b0;
    end else if (osc_preset) begin
      main_rdy_ff <= 1'b0;
    end else if (main_rdy_set) begin
      main_rdy_ff <= 1'b1;
    end
  end

  // Alternate ready stays set until power is removed.
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      alt_rdy_ff <= 1'b0;
    end else if (alt_rdy_set) begin
      alt_rdy_ff <= 1'b1;
    end
  end

  // Main enable also lives across system resets, since power-on starts the oscillator.
  always_ff @(posedge ref_clk or negedge por_n) begin
    if (!por_n) begin
      main_en_ff <= 1'b1;
    end else if (wr && hit(avs_address, ctbc_pkg::ADDR_MISC)) begin
      main_en_ff <= avs_writedata[ctbc_pkg::MISC_MAIN_EN];
    end
  end

  // Miscellaneous control bits.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sys_sel_ff <= ctbc_pkg::SYS_MAIN_DIV64;
      opt_ff     <= 1'b0;
    end else if (wr && hit(avs_address, ctbc_pkg::ADDR_MISC)) begin
      sys_sel_ff <= {avs_writedata[ctbc_pkg::MISC_SYS_HI], avs_writedata[ctbc_pkg::MISC_SYS_LO]};
      opt_ff     <= avs_writedata[ctbc_pkg::MISC_OPT_MAP];
    end
  end

  // Time base control with one-shot source select.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      tbc_ff         <= ctbc_pkg::TBC_RESET;
      src_written_ff <= 1'b0;
    end else if (wr && hit(avs_address, ctbc_pkg::ADDR_TBC)) begin
      tbc_ff[ctbc_pkg::TBC_LCD_BIT] <= avs_writedata[ctbc_pkg::TBC_LCD_BIT];
      tbc_ff[ctbc_pkg::TBC_RATE_HI] <= avs_writedata[ctbc_pkg::TBC_RATE_HI];
      tbc_ff[ctbc_pkg::TBC_RATE_LO] <= avs_writedata[ctbc_pkg::TBC_RATE_LO];
      src_written_ff                <= 1'b1;
      if (!src_written_ff) begin
        tbc_ff[ctbc_pkg::TBC_SRC_BIT] <= avs_writedata[ctbc_pkg::TBC_SRC_BIT];
      end
    end
  end

  // System clock level from the selected prescaler tap.
  always_comb begin
    case (sys_sel_ff)
      ctbc_pkg::SYS_MAIN_DIV2:  sys_lvl = sys_pre[0];
      ctbc_pkg::SYS_MAIN_DIV4:  sys_lvl = sys_pre[1];
      ctbc_pkg::SYS_MAIN_DIV64: sys_lvl = sys_pre[5];
      ctbc_pkg::SYS_ALT_DIV2:   sys_lvl = tb_pre[0];
      default:                  sys_lvl = sys_pre[5];
    endcase
  end

  ctbc_edge u_sys_edge (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .lvl     (sys_lvl),
    .pulse   (sys_pulse)
  );

  ctbc_edge u_tb_edge (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .lvl     (tb_pre[0]),
    .pulse   (tb_pulse)
  );

  // LCD clock: main/2^13 is tb bit 5 of main/128; alternate/2^6 is tb bit 5.
  assign lcd_lvl = tbc_ff[ctbc_pkg::TBC_LCD_BIT] ? tb_pre[ctbc_pkg::TB_LCD_MAIN_LO + 1]
                                                 : tb_pre[ctbc_pkg::TB_LCD_ALT_LO];

  always_comb begin
    case (tbc_ff[ctbc_pkg::TBC_RATE_HI:ctbc_pkg::TBC_RATE_LO])
      2'h0:    t2_lvl = sys_pulse;
      2'h1:    t2_lvl = sys_pulse & (t2_pre[1:0] == 2'h3);
      2'h2:    t2_lvl = sys_pulse & (t2_pre[4:0] == 5'h1F);
      2'h3:    t2_lvl = sys_pulse & (t2_pre == 8'hFF);
      default: t2_lvl = sys_pulse;
    endcase
  end

  // The time base tick marks each rise of the first time base stage, so it runs at half the source rate.
  // Registered clock enables out.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sys_ff <= 1'b0;
      tb_ff  <= 1'b0;
      lcd_ff <= 1'b0;
      t2_ff  <= 1'b0;
    end else begin
      sys_ff <= sys_pulse;
      tb_ff  <= tb_pulse;
      lcd_ff <= lcd_lvl;
      t2_ff  <= t2_lvl;
    end
  end

  // Ready events are sticky; a read clears them but a same-cycle set wins.
  always_comb begin
    nxt_ista = ista_ff;
    if (rd && hit(avs_address, ctbc_pkg::ADDR_IRQ_STATUS)) begin
      nxt_ista = 2'h0;
    end
    if (main_rdy_set && !main_rdy_ff) begin
      nxt_ista[ctbc_pkg::IRQ_MAIN_RDY] = 1'b1;
    end
    if (alt_rdy_set && !alt_rdy_ff) begin
      nxt_ista[ctbc_pkg::IRQ_ALT_RDY] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ista_ff  <= 2'h0;
      imask_ff <= 2'h0;
      irq_ff   <= 1'b0;
    end else begin
      ista_ff <= nxt_ista;
      irq_ff  <= |(nxt_ista & imask_ff);
      if (wr && hit(avs_address, ctbc_pkg::ADDR_IRQ_MASK)) begin
        imask_ff <= avs_writedata[1:0];
      end
    end
  end

  // Read data mux; unmapped addresses read zero.
  always_comb begin
    nxt_rdata = 8'h00;
    if (hit(avs_address, ctbc_pkg::ADDR_TBC)) begin
      nxt_rdata = tbc_ff & ctbc_pkg::TBC_WMASK;
    end else if (hit(avs_address, ctbc_pkg::ADDR_MISC)) begin
      nxt_rdata[ctbc_pkg::MISC_SYS_HI]   = sys_sel_ff[1];
      nxt_rdata[ctbc_pkg::MISC_SYS_LO]   = sys_sel_ff[0];
      nxt_rdata[ctbc_pkg::MISC_MAIN_RDY] = main_rdy_ff;
      nxt_rdata[ctbc_pkg::MISC_ALT_RDY]  = alt_rdy_ff;
      nxt_rdata[ctbc_pkg::MISC_MAIN_EN]  = main_en_ff;
      nxt_rdata[ctbc_pkg::MISC_OPT_MAP]  = opt_ff;
    end else if (hit(avs_address, ctbc_pkg::ADDR_IRQ_STATUS)) begin
      nxt_rdata = {6'h00, ista_ff};
    end else if (hit(avs_address, ctbc_pkg::ADDR_IRQ_MASK)) begin
      nxt_rdata = {6'h00, imask_ff};
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (rd) begin
      rdata_ff <= nxt_rdata;
    end
  end

  // Every output below is driven straight from a register.
  assign avs_readdata       = rdata_ff;
  assign main_osc_run       = main_en_ff;
  assign sysclk_tick        = sys_ff;
  assign tb_tick            = tb_ff;
  assign lcd_clk_tick       = lcd_ff;
  assign tmr2_prescaled_clk = t2_ff;
  assign option_map_sel     = opt_ff;
  assign irq                = irq_ff;
endmodule : ctbc_top

// file: ctbc_top_sva.sv
// Concurrent assertions on the ports of the clock and time base block.
module ctbc_top_sva (
  // Clock and resets
  input wire logic       ref_clk,
  input wire logic       resetn,
  input wire logic       por_n,
  // Oscillator ticks
  input wire logic       main_osc_tick,
  input wire logic       alt_osc_tick,
  // Register bus
  input wire logic [7:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic [7:0] avs_writedata,
  input wire logic [7:0] avs_readdata,
  input wire logic       avs_waitrequest,
  // Clock enables and status
  input wire logic       main_osc_run,
  input wire logic       sysclk_tick,
  input wire logic       tb_tick,
  input wire logic       lcd_clk_tick,
  input wire logic       tmr2_prescaled_clk,
  input wire logic       option_map_sel,
  input wire logic       irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic rd_done;
  logic wr_done;
  assign rd_done = avs_read && !avs_waitrequest;
  assign wr_done = avs_write && !avs_waitrequest;

  a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered after one cycle");
  a_wait_single: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_wait_idle: assert property (!(avs_read || avs_write) && avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest dropped without a request");
  a_unmapped_zero: assert property (rd_done && !(avs_address inside {[8'h10:8'h13]}) |-> avs_readdata == 8'h00)
    else $error("unmapped address read nonzero");
  a_tbc_reserved: assert property (rd_done && avs_address == ctbc_pkg::ADDR_TBC |-> (avs_readdata & ~ctbc_pkg::TBC_WMASK) == 8'h00)
    else $error("reserved time base control bits read nonzero");
  a_main_enable: assert property (wr_done && avs_address == ctbc_pkg::ADDR_MISC |=> main_osc_run == $past(avs_writedata[3]))
    else $error("main oscillator run does not follow enable write");
  a_opt_map: assert property (wr_done && avs_address == ctbc_pkg::ADDR_MISC |=> option_map_sel == $past(avs_writedata[2]))
    else $error("option map select does not follow write");
  a_sys_pulse: assert property (sysclk_tick |=> !sysclk_tick)
    else $error("system clock tick longer than one cycle");
  // A write to the time base control register may legally re-select the LCD tap and cut the high phase.
  a_lcd_hold: assert property ($rose(lcd_clk_tick) |=> (lcd_clk_tick [*8]) or (##[0:8] (avs_write && avs_address == ctbc_pkg::ADDR_TBC)))
    else $error("lcd clock high phase too short");
  a_irq_read_clr: assert property (rd_done && avs_address == ctbc_pkg::ADDR_IRQ_STATUS |=> ##[0:1] !irq)
    else $error("irq stays high after status read");

  c_irq_rise: cover property ($rose(irq));
  c_main_stop: cover property ($fell(main_osc_run));
  c_tmr2_tick: cover property (tmr2_prescaled_clk);
endmodule : ctbc_top_sva

bind ctbc_top ctbc_top_sva ctbc_top_sva_inst (.ref_clk(ref_clk), .resetn(resetn), .por_n(por_n),
  .main_osc_tick(main_osc_tick), .alt_osc_tick(alt_osc_tick), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .main_osc_run(main_osc_run), .sysclk_tick(sysclk_tick), .tb_tick(tb_tick),
  .lcd_clk_tick(lcd_clk_tick), .tmr2_prescaled_clk(tmr2_prescaled_clk), .option_map_sel(option_map_sel), .irq(irq));

// file: ctbc_top_tb.sv
// Self-checking testbench for the clock and time base block.
module ctbc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk, resetn, por_n, main_osc_tick, alt_osc_tick, avs_read, avs_write, avs_waitrequest;
  logic       main_osc_run, sysclk_tick, tb_tick, lcd_clk_tick, tmr2_prescaled_clk, option_map_sel, irq;
  logic [7:0] avs_address, avs_writedata, avs_readdata, q, opt, a;
  logic [1:0] acnt;
  logic [31:0] rs;
  int         error_cnt, n_checks, cyc, t0, p, t, n;

  ctbc_top ctbc_top_inst (.ref_clk(ref_clk), .resetn(resetn), .por_n(por_n), .main_osc_tick(main_osc_tick),
    .alt_osc_tick(alt_osc_tick), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .main_osc_run(main_osc_run), .sysclk_tick(sysclk_tick), .tb_tick(tb_tick), .lcd_clk_tick(lcd_clk_tick),
    .tmr2_prescaled_clk(tmr2_prescaled_clk), .option_map_sel(option_map_sel), .irq(irq));

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // Main oscillator edge every 2 cycles, alternate every 3, so the two sources give distinct periods.
  always @(posedge ref_clk) begin
    main_osc_tick <= ~main_osc_tick;
    acnt <= (acnt == 2'h2) ? 2'h0 : acnt + 2'h1;
    alt_osc_tick <= (acnt == 2'h2);
    cyc <= cyc + 1;
  end

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : xs

  function automatic int sys_per(input logic [1:0] c);
    return (c == 2'h3) ? 6 : (c == 2'h0) ? 4 : (c == 2'h1) ? 8 : 128;
  endfunction : sys_per

  function automatic logic sig(input int s);
    case (s)
      0: return sysclk_tick;
      1: return tmr2_prescaled_clk;
      2: return tb_tick;
      default: return lcd_clk_tick;
    endcase
  endfunction : sig

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [7:0] ad, input logic [7:0] d);
    @(posedge ref_clk);
    avs_write <= we;
    avs_read <= ~we;
    avs_address <= ad;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rd(input logic [7:0] ad, input logic [7:0] exp, input string nm);
    bus(1'b0, ad, 8'h00);
    chk(nm, q, exp);
  endtask : rd

  // Period in cycles between the second and third rising edge seen.
  task automatic per(input int s);
    logic pv;
    int c;
    pv = 1'b1;
    c = 0;
    p = 0;
    while (c < 3 && p < 40000) begin
      @(posedge ref_clk);
      if (sig(s) === 1'b1 && pv !== 1'b1) c++;
      if (c == 2) p++;
      pv = sig(s);
    end
  endtask : per

  task automatic wirq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wirq

  task automatic wcyc(input int target);
    while (cyc - t0 < target) @(posedge ref_clk);
  endtask : wcyc

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    complete_run();
  end

  initial begin
    rs = 32'h23;
    {resetn, por_n, main_osc_tick, alt_osc_tick, avs_read, avs_write} = 6'h00;
    {avs_address, avs_writedata, acnt} = 18'h00000;
    cyc = 0;
    error_cnt = 0;
    n_checks = 0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    por_n <= 1'b1;
    t0 = cyc;
    rd(ctbc_pkg::ADDR_MISC, 8'h88, "misc after power-on");
    rd(ctbc_pkg::ADDR_TBC, ctbc_pkg::TBC_RESET, "tbc after power-on");
    bus(1'b1, ctbc_pkg::ADDR_IRQ_MASK, 8'h03);
    opt = 8'(xs() & 32'h4);
    bus(1'b1, ctbc_pkg::ADDR_MISC, 8'h88 | opt);
    @(negedge ref_clk);
    chk("option map", option_map_sel, opt[2]);
    a = 8'h14 + 8'(xs() % 32'd236);
    bus(1'b1, a, 8'(xs()));
    rd(a, 8'h00, "unmapped read");
    rd(ctbc_pkg::ADDR_MISC, 8'h88 | opt, "misc kept");
    wirq(20000);
    t = cyc - t0;
    chk("main ready time", (t >= 16130 && t <= 16190), 1'b1);
    rd(ctbc_pkg::ADDR_IRQ_STATUS, 8'h01, "status main ready");
    @(negedge ref_clk);
    chk("irq cleared", irq, 1'b0);
    rd(ctbc_pkg::ADDR_IRQ_STATUS, 8'h00, "status cleared");
    rd(ctbc_pkg::ADDR_MISC, 8'hA8 | opt, "misc main ready");
    for (int c = 2; c >= 0; c--) begin
      bus(1'b1, ctbc_pkg::ADDR_MISC, {2'(c), 6'h08} | opt);
      per(0);
      chk("system clock period", p, sys_per(2'(c)));
    end
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ctbc_pkg::ADDR_TBC, {i != 0, 7'h5C} | 8'(i));
      rd(ctbc_pkg::ADDR_TBC, 8'(i), "tbc readback");
      per(1);
      chk("timer 2 period", p, 4 << (i == 0 ? 0 : 3 * i - 1));
    end
    per(2);
    chk("alternate time base", p, 6);
    for (int l = 0; l < 2; l++) begin
      bus(1'b1, ctbc_pkg::ADDR_TBC, {2'h2, 1'(l), 5'h00});
      per(3);
      chk("lcd period", p, 192 << l);
    end
    bus(1'b1, ctbc_pkg::ADDR_IRQ_MASK, 8'h01);
    wcyc(24150);
    rd(ctbc_pkg::ADDR_IRQ_STATUS, 8'h00, "alternate not early");
    wcyc(24300);
    @(negedge ref_clk);
    chk("masked irq", irq, 1'b0);
    bus(1'b1, ctbc_pkg::ADDR_IRQ_MASK, 8'h03);
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("unmasked irq", irq, 1'b1);
    rd(ctbc_pkg::ADDR_IRQ_STATUS, 8'h02, "status alternate ready");
    rd(ctbc_pkg::ADDR_MISC, 8'h38 | opt, "misc alternate ready");
    // Alternate source is picked only now that its ready flag is set.
    bus(1'b1, ctbc_pkg::ADDR_MISC, 8'hC8 | opt);
    per(0);
    chk("alternate system clock", p, sys_per(2'h3));
    bus(1'b1, ctbc_pkg::ADDR_MISC, 8'h80 | opt);
    rd(ctbc_pkg::ADDR_MISC, 8'h90 | opt, "main disabled");
    n = 0;
    repeat (400) begin
      @(posedge ref_clk);
      if (sysclk_tick === 1'b1) n++;
    end
    chk("stopped system clock", n, 0);
    bus(1'b1, ctbc_pkg::ADDR_MISC, 8'h88 | opt);
    t = cyc;
    wirq(20000);
    chk("restart ready time", (cyc - t >= 16130 && cyc - t <= 16190), 1'b1);
    rd(ctbc_pkg::ADDR_IRQ_STATUS, 8'h01, "status restart");
    resetn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(ctbc_pkg::ADDR_MISC, 8'hB8, "misc after reset");
    bus(1'b1, ctbc_pkg::ADDR_TBC, 8'h80);
    bus(1'b1, ctbc_pkg::ADDR_TBC, 8'h00);
    rd(ctbc_pkg::ADDR_TBC, 8'h80, "tbc single write");
    per(2);
    chk("main time base", p, 512);
    complete_run();
  end
endmodule : ctbc_top_tb
